// ### rtl/vhz_setpoint.sv
`timescale 1ns/1ps
`include "vhz_defines.svh"

module vhz_setpoint
(
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst,
	// settings, taken on cfg_load
	input  wire logic               cfg_load,
	input  wire logic [15:0]        start_voltage,
	input  wire logic signed [8:0]  boost_voltage_fraction,
	input  wire logic [6:0]         boost_frequency_fraction,
	input  wire logic [15:0]        end_voltage,
	input  wire logic [15:0]        end_frequency,
	input  wire logic [15:0]        lowest_frequency,
	input  wire logic [15:0]        highest_frequency,
	input  wire logic [7:0]         precontrol_scale,
	// motor rating, taken on rating_load when cfg_load is low
	input  wire logic               rating_load,
	input  wire logic [15:0]        rated_voltage,
	input  wire logic [15:0]        rated_frequency,
	input  wire logic               rated_delta,
	// control cycle
	input  wire logic               cycle_start,
	input  wire logic [15:0]        frequency_in,
	input  wire logic signed [15:0] precontrol_in,
	// result
	output logic [15:0]             voltage_out,
	output logic                    voltage_valid,
	output logic                    busy
);
	import vhz_pkg::*;

	vhz_state_s st_reg;
	vhz_state_s st_next;
	logic        div_done;
	logic [31:0] div_q;

	vhz_udiv u_div
	(
		.ref_clk  (ref_clk),
		.rst      (rst),
		.go       (st_reg.div_go),
		.num      (st_reg.div_num),
		.den      (st_reg.div_den),
		.done     (div_done),
		.quotient (div_q)
	);

	function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		if (v < {16'h0000, lo})
			return lo;
		else if (v > {16'h0000, hi})
			return hi;
		else
			return v[15:0];
	endfunction

	always_comb
	begin
		logic signed [31:0] q_signed;
		logic signed [31:0] diff;
		logic signed [31:0] sum;
		logic [31:0]        delta_f;
		q_signed = st_reg.div_neg ? -$signed(div_q) : $signed(div_q);
		diff     = 32'sh0000_0000;
		sum      = 32'sh0000_0000;
		delta_f  = 32'h0000_0000;
		st_next  = st_reg;
		st_next.div_go = 1'b0;
		st_next.valid  = 1'b0;

		if (cfg_load)
		begin
			st_next.start_v = clamp16({16'h0000, start_voltage}, 16'h0000,
				`VHZ_START_V_MAX);
			if (boost_voltage_fraction < `VHZ_BOOST_V_MIN)
				st_next.boost_v_pct = `VHZ_BOOST_V_MIN;
			else if (boost_voltage_fraction > `VHZ_BOOST_V_MAX)
				st_next.boost_v_pct = `VHZ_BOOST_V_MAX;
			else
				st_next.boost_v_pct = boost_voltage_fraction;
			st_next.boost_f_pct = (boost_frequency_fraction > `VHZ_BOOST_F_MAX)
				? `VHZ_BOOST_F_MAX : boost_frequency_fraction;
			st_next.end_v  = clamp16({16'h0000, end_voltage}, `VHZ_END_V_MIN,
				`VHZ_END_V_MAX);
			st_next.end_f  = clamp16({16'h0000, end_frequency}, 16'h0000,
				`VHZ_END_F_MAX);
			st_next.low_f  = lowest_frequency;
			st_next.high_f = highest_frequency;
			st_next.pre_pct = (precontrol_scale > `VHZ_PRE_MAX) ? `VHZ_PRE_MAX
				: precontrol_scale;
		end
		else if (rating_load)
		begin
			st_next.end_v = clamp16({16'h0000, rated_voltage}, `VHZ_END_V_MIN,
				`VHZ_END_V_MAX);
			if (rated_delta)
				delta_f = ({16'h0000, rated_frequency} * `VHZ_SQRT3_MUL)
					>> `VHZ_SQRT3_SHIFT;
			else
				delta_f = {16'h0000, rated_frequency};
			st_next.end_f = clamp16(delta_f, 16'h0000, `VHZ_END_F_MAX);
		end

		unique case (st_reg.st)
			VHZ_IDLE:
			begin
				if (cycle_start)
				begin
					if (frequency_in > st_reg.high_f)
						st_next.f_work = st_reg.high_f;
					else if (frequency_in < st_reg.low_f)
						st_next.f_work = st_reg.low_f;
					else
						st_next.f_work = frequency_in;
					st_next.div_num = {16'h0000, st_reg.end_f} * {25'h0000000,
						st_reg.boost_f_pct};
					st_next.div_den = `VHZ_PERCENT;
					st_next.div_neg = 1'b0;
					st_next.div_go  = 1'b1;
					st_next.st      = VHZ_FK;
				end
			end
			VHZ_FK:
			begin
				if (div_done)
				begin
					st_next.f_k = div_q[15:0];
					diff = $signed({16'h0000, st_reg.end_v}) - $signed({16'h0000,
						st_reg.start_v});
					st_next.div_neg = diff < 0;
					st_next.div_num = ((diff < 0) ? -diff : diff) * $signed({16'h0000,
						div_q[15:0]});
					st_next.div_den = {16'h0000, st_reg.end_f};
					st_next.div_go  = 1'b1;
					st_next.st      = VHZ_VLIN;
				end
			end
			VHZ_VLIN:
			begin
				if (div_done)
				begin
					sum = q_signed + $signed({16'h0000, st_reg.start_v});
					st_next.div_num = 32'(sum) * 32'(32'sh0000_0064 + 32'(st_reg.boost_v_pct));
					st_next.div_den = `VHZ_PERCENT;
					st_next.div_neg = 1'b0;
					st_next.div_go  = 1'b1;
					st_next.st      = VHZ_VK;
				end
			end
			VHZ_VK:
			begin
				if (div_done)
				begin
					st_next.v_k = clamp16(div_q, 16'h0000, 16'hFFFF);
					st_next.div_go = 1'b1;
					if (st_reg.f_work >= st_reg.end_f)
					begin
						st_next.acc     = $signed({16'h0000, st_reg.end_v});
						st_next.div_neg = precontrol_in < 0;
						st_next.div_num = 32'(((precontrol_in < 0) ? -32'(precontrol_in)
							: 32'(precontrol_in)) * $signed({24'h000000,
							st_reg.pre_pct}));
						st_next.div_den = `VHZ_PERCENT;
						st_next.st      = VHZ_PRE;
					end
					else if (st_reg.f_work >= st_reg.f_k)
					begin
						st_next.acc = $signed({16'h0000, st_next.v_k});
						diff = $signed({16'h0000, st_reg.end_v}) - st_next.acc;
						st_next.div_neg = diff < 0;
						st_next.div_num = ((diff < 0) ? -diff : diff)
							* $signed({16'h0000, st_reg.f_work - st_reg.f_k});
						st_next.div_den = {16'h0000, st_reg.end_f - st_reg.f_k};
						st_next.st      = VHZ_SEG;
					end
					else
					begin
						st_next.acc = $signed({16'h0000, st_reg.start_v});
						diff = $signed({16'h0000, st_next.v_k}) - st_next.acc;
						st_next.div_neg = diff < 0;
						st_next.div_num = ((diff < 0) ? -diff : diff)
							* $signed({16'h0000, st_reg.f_work});
						st_next.div_den = {16'h0000, st_reg.f_k};
						st_next.st      = VHZ_SEG;
					end
				end
			end
			VHZ_SEG:
			begin
				if (div_done)
				begin
					st_next.acc     = st_reg.acc + q_signed;
					st_next.div_neg = precontrol_in < 0;
					st_next.div_num = 32'(((precontrol_in < 0) ? -32'(precontrol_in)
						: 32'(precontrol_in)) * $signed({24'h000000, st_reg.pre_pct}));
					st_next.div_den = `VHZ_PERCENT;
					st_next.div_go  = 1'b1;
					st_next.st      = VHZ_PRE;
				end
			end
			VHZ_PRE:
			begin
				if (div_done)
				begin
					sum = st_reg.acc + q_signed;
					if (sum < 0)
						st_next.volt = 16'h0000;
					else
						st_next.volt = clamp16(32'(sum), 16'h0000, 16'hFFFF);
					st_next.valid = 1'b1;
					st_next.st    = VHZ_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st_reg             <= '0;
			st_reg.st          <= VHZ_IDLE;
			st_reg.start_v     <= `VHZ_START_V_DEF;
			st_reg.boost_v_pct <= `VHZ_BOOST_V_DEF;
			st_reg.boost_f_pct <= `VHZ_BOOST_F_DEF;
			st_reg.end_v       <= `VHZ_END_V_DEF;
			st_reg.end_f       <= `VHZ_END_F_DEF;
			st_reg.low_f       <= `VHZ_LOW_F_DEF;
			st_reg.high_f      <= `VHZ_HIGH_F_DEF;
			st_reg.pre_pct     <= `VHZ_PRE_DEF;
		end
		else
			st_reg <= st_next;
	end

	assign voltage_out   = st_reg.volt;
	assign voltage_valid = st_reg.valid;
	assign busy          = (st_reg.st != VHZ_IDLE);

endmodule // vhz_setpoint

// ### rtl/vhz_defines.svh
`ifndef VHZ_DEFINES_SVH
`define VHZ_DEFINES_SVH

// voltages in 0.1 V, frequencies in 0.01 Hz, fractions in whole percent
`define VHZ_START_V_DEF   16'h0032
`define VHZ_START_V_MAX   16'h03E8
`define VHZ_BOOST_V_DEF   9'sh00A
`define VHZ_BOOST_V_MIN   (-9'sh064)
`define VHZ_BOOST_V_MAX   9'sh0C8
`define VHZ_BOOST_F_DEF   7'h14
`define VHZ_BOOST_F_MAX   7'h64
`define VHZ_END_V_DEF     16'h0FA0
`define VHZ_END_V_MIN     16'h0258
`define VHZ_END_V_MAX     16'h15E0
`define VHZ_END_F_DEF     16'h1388
`define VHZ_END_F_MAX     16'hE9FC
`define VHZ_LOW_F_DEF     16'h0000
`define VHZ_HIGH_F_DEF    16'h1388
`define VHZ_PRE_DEF       8'h64
`define VHZ_PRE_MAX       8'hC8
`define VHZ_PERCENT       32'h0000_0064
`define VHZ_SQRT3_MUL     32'h0000_6EDA
`define VHZ_SQRT3_SHIFT   14
`define VHZ_DIV_STEPS     6'h20

`endif

// ### rtl/vhz_pkg.sv
package vhz_pkg;

	typedef enum logic [2:0] {
		VHZ_IDLE,
		VHZ_FK,
		VHZ_VLIN,
		VHZ_VK,
		VHZ_SEG,
		VHZ_PRE
	} vhz_state_e;

	typedef struct packed {
		logic        busy;
		logic        done;
		logic [5:0]  count;
		logic [32:0] rem;
		logic [31:0] quo;
		logic [31:0] den;
		logic [31:0] result;
	} vhz_div_s;

	typedef struct packed {
		vhz_state_e         st;
		logic [15:0]        start_v;
		logic signed [8:0]  boost_v_pct;
		logic [6:0]         boost_f_pct;
		logic [15:0]        end_v;
		logic [15:0]        end_f;
		logic [15:0]        low_f;
		logic [15:0]        high_f;
		logic [7:0]         pre_pct;
		logic [15:0]        f_work;
		logic [15:0]        f_k;
		logic [15:0]        v_k;
		logic signed [31:0] acc;
		logic               div_go;
		logic [31:0]        div_num;
		logic [31:0]        div_den;
		logic               div_neg;
		logic [15:0]        volt;
		logic               valid;
	} vhz_state_s;

endpackage

// ### rtl/vhz_udiv.sv
`timescale 1ns/1ps
`include "vhz_defines.svh"

// unsigned restoring divider, one quotient bit per clock; divide by zero gives zero
module vhz_udiv
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// request
	input  wire logic        go,
	input  wire logic [31:0] num,
	input  wire logic [31:0] den,
	// answer
	output logic             done,
	output logic [31:0]      quotient
);
	import vhz_pkg::*;

	vhz_div_s div_reg;
	vhz_div_s div_next;

	always_comb
	begin
		logic [32:0] trial;
		trial    = 33'h0_0000_0000;
		div_next = div_reg;
		div_next.done = 1'b0;
		if (go)
		begin
			div_next.busy  = 1'b1;
			div_next.count = `VHZ_DIV_STEPS;
			div_next.rem   = 33'h0_0000_0000;
			div_next.quo   = num;
			div_next.den   = den;
		end
		else if (div_reg.busy)
		begin
			trial = {div_reg.rem[31:0], div_reg.quo[31]};
			if (trial >= {1'b0, div_reg.den})
			begin
				div_next.rem = trial - {1'b0, div_reg.den};
				div_next.quo = {div_reg.quo[30:0], 1'b1};
			end
			else
			begin
				div_next.rem = trial;
				div_next.quo = {div_reg.quo[30:0], 1'b0};
			end
			div_next.count = div_reg.count - 6'h01;
			if (div_reg.count == 6'h01)
			begin
				div_next.busy   = 1'b0;
				div_next.done   = 1'b1;
				div_next.result = (div_reg.den == 32'h0000_0000) ? 32'h0000_0000
					: div_next.quo;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			div_reg <= '0;
		else
			div_reg <= div_next;
	end

	assign done     = div_reg.done;
	assign quotient = div_reg.result;

endmodule // vhz_udiv

// ### bench/vhz_setpoint_checker.sv
`timescale 1ns/1ps
module vhz_setpoint_checker
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// control cycle
	input  wire logic        cycle_start,
	// result
	input  wire logic [15:0] voltage_out,
	input  wire logic        voltage_valid,
	input  wire logic        busy
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence s_launch;
		cycle_start && !busy;
	endsequence
	sequence s_finish;
		voltage_valid && !busy;
	endsequence

	property p_launch_busy;
		s_launch |=> busy;
	endproperty
	property p_no_early;
		s_launch |=> (busy && !voltage_valid) [*8];
	endproperty
	property p_answer_time;
		s_launch |=> ##[60:250] s_finish;
	endproperty
	property p_busy_holds;
		busy && !voltage_valid |=> busy || voltage_valid;
	endproperty
	property p_valid_pulse;
		voltage_valid |=> !voltage_valid;
	endproperty
	property p_valid_from_busy;
		voltage_valid |-> $past(busy);
	endproperty
	property p_out_holds;
		!voltage_valid |-> $stable(voltage_out);
	endproperty
	property p_reset_clear;
		$past(rst) |-> voltage_out == 16'h0000 && !voltage_valid && !busy;
	endproperty

	a_launch_busy: assert property (p_launch_busy) else $error("busy not raised");
	a_no_early: assert property (p_no_early) else $error("result too early");
	a_answer_time: assert property (p_answer_time) else $error("no result in time");
	a_busy_holds: assert property (p_busy_holds) else $error("busy dropped");
	a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
	a_valid_from_busy: assert property (p_valid_from_busy) else $error("valid idle");
	a_out_holds: assert property (p_out_holds) else $error("output moved");
	a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");
endmodule // vhz_setpoint_checker

bind vhz_setpoint vhz_setpoint_checker chk_u (.ref_clk(ref_clk), .rst(rst),
	.cycle_start(cycle_start), .voltage_out(voltage_out), .voltage_valid(voltage_valid),
	.busy(busy));

// ### bench/vhz_stage_model.sv
`timescale 1ns/1ps
module vhz_stage_model
(
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst,
	// setpoint from the block
	input  wire logic [15:0]        voltage_out,
	input  wire logic               voltage_valid,
	// current-limit demand
	input  wire logic signed [15:0] demand,
	// pre-control and applied setpoint
	output logic signed [15:0]      precontrol_in,
	output logic [15:0]             applied_v
);
	assign precontrol_in = demand;
	// setpoint takes effect on each valid pulse
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			applied_v <= 16'h0000;
		else if (voltage_valid)
			applied_v <= voltage_out;
	end
endmodule // vhz_stage_model

// ### bench/vhz_setpoint_test.sv
`timescale 1ns/1ps
module vhz_setpoint_test;
	logic               ref_clk, rst, cfg_load, rating_load, rated_delta, cycle_start;
	logic [15:0]        start_voltage, end_voltage, end_frequency, lowest_frequency;
	logic [15:0]        highest_frequency, rated_voltage, rated_frequency, frequency_in;
	logic signed [8:0]  boost_voltage_fraction;
	logic [6:0]         boost_frequency_fraction;
	logic [7:0]         precontrol_scale;
	logic signed [15:0] precontrol_in, demand;
	logic [15:0]        voltage_out, applied_v;
	logic               voltage_valid, busy;
	int                 err_count, n_checks, sv, bv, rf, ev, ef, lo, hi, sc, last_v;

	vhz_setpoint dut_u (.ref_clk(ref_clk), .rst(rst), .cfg_load(cfg_load),
		.start_voltage(start_voltage), .boost_voltage_fraction(boost_voltage_fraction),
		.boost_frequency_fraction(boost_frequency_fraction), .end_voltage(end_voltage),
		.end_frequency(end_frequency), .lowest_frequency(lowest_frequency),
		.highest_frequency(highest_frequency), .precontrol_scale(precontrol_scale),
		.rating_load(rating_load), .rated_voltage(rated_voltage),
		.rated_frequency(rated_frequency), .rated_delta(rated_delta),
		.cycle_start(cycle_start), .frequency_in(frequency_in),
		.precontrol_in(precontrol_in), .voltage_out(voltage_out),
		.voltage_valid(voltage_valid), .busy(busy));

	vhz_stage_model stage_u (.ref_clk(ref_clk), .rst(rst), .voltage_out(voltage_out),
		.voltage_valid(voltage_valid), .demand(demand), .precontrol_in(precontrol_in),
		.applied_v(applied_v));

	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic tally_and_finish();
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	function automatic int model(input int f, input int p);
		int fw, fk, vl, vk, v, a;
		fw = f < lo ? lo : (f > hi ? hi : f);
		fk = ef * rf / 100;
		vl = ef == 0 ? sv : (ev - sv) * fk / ef + sv;
		vk = vl * (100 + bv) / 100;
		if (fw >= ef)
			v = ev;
		else if (fw < fk)
			v = sv + (vk - sv) * fw / fk;
		else
			v = vk + (ev - vk) * (fw - fk) / (ef - fk);
		a = (p < 0 ? -p : p) * sc / 100;
		v = p < 0 ? v - a : v + a;
		return v < 0 ? 0 : (v > 65535 ? 65535 : v);
	endfunction

	// one control cycle; poke retries a start while busy
	task automatic run(input int f, input int p, input bit poke);
		int n;
		@(negedge ref_clk);
		chk("applied_v", 16'(last_v), applied_v);
		last_v = model(f, p);
		frequency_in = 16'(f);
		demand = 16'(p);
		cycle_start = 1'b1;
		@(negedge ref_clk);
		cycle_start = 1'b0;
		if (poke)
		begin
			repeat (3) @(negedge ref_clk);
			frequency_in = 16'h0000;
			cycle_start = 1'b1;
			@(negedge ref_clk);
			cycle_start = 1'b0;
		end
		n = 0;
		while (voltage_valid !== 1'b1 && n < 400)
		begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 400)
		begin
			err_count++;
			tally_and_finish();
		end
		chk("voltage_out", 16'(last_v), voltage_out);
	endtask

	task automatic cfg(input int s, b, r, e, fe, l, h, c);
		@(negedge ref_clk);
		start_voltage = 16'(s);
		boost_voltage_fraction = 9'(b);
		boost_frequency_fraction = 7'(r);
		end_voltage = 16'(e);
		end_frequency = 16'(fe);
		lowest_frequency = 16'(l);
		highest_frequency = 16'(h);
		precontrol_scale = 8'(c);
		cfg_load = 1'b1;
		sv = s > 1000 ? 1000 : s;
		{bv, rf, ev, ef, lo, hi, sc} = {b, r, e, fe, l, h, c};
		@(negedge ref_clk);
		cfg_load = 1'b0;
	endtask

	task automatic rate(input int v, input int f, input bit d);
		@(negedge ref_clk);
		rated_voltage = 16'(v);
		rated_frequency = 16'(f);
		rated_delta = d;
		rating_load = 1'b1;
		ev = v;
		ef = d ? f * 28378 / 16384 : f;
		@(negedge ref_clk);
		rating_load = 1'b0;
	endtask

	initial
	begin
		{rst, cfg_load, rating_load, rated_delta, cycle_start} = 5'h10;
		{start_voltage, end_voltage, end_frequency, lowest_frequency} = 64'h0;
		{highest_frequency, rated_voltage, rated_frequency, frequency_in} = 64'h0;
		{boost_voltage_fraction, boost_frequency_fraction, precontrol_scale} = 24'h0;
		demand = 16'sh0000;
		sv = 50;
		bv = 10;
		rf = 20;
		ev = 4000;
		ef = 5000;
		lo = 0;
		hi = 5000;
		sc = 100;
		last_v = 0;
		err_count = 0;
		n_checks = 0;
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		run(0, 0, 0);
		run(1000, 0, 0);
		run(3000, 0, 1);
		run(5000, 0, 0);
		run(7000, 0, 0);
		run(1000, 100, 0);
		run(500, -300, 0);
		cfg(50, 0, 50, 4000, 5000, 0, 5000, 100);
		run(2500, 0, 0);
		cfg(2000, -100, 0, 600, 10000, 1500, 20000, 200);
		run(0, -50, 0);
		run(15000, 0, 0);
		cfg(0, 200, 100, 5600, 59900, 0, 65535, 0);
		run(30000, 1000, 0);
		cfg(50, 10, 20, 4000, 5000, 0, 20000, 100);
		rate(3800, 5000, 1);
		run(8660, 0, 0);
		run(8000, 0, 0);
		rate(4000, 5000, 0);
		run(1000, 0, 0);
		tally_and_finish();
	end
endmodule // vhz_setpoint_test
